// ### bcs_params.svh
// Purpose: constants for the boot clock source select block
// Assumes: included by bare name before use
// Notes: bit positions index the reset configuration word from bit 0
`ifndef BCS_PARAMS_SVH
`define BCS_PARAMS_SVH

// sizes
`define BCS_RCW_W 256
`define BCS_CORES 8

// configuration word field positions
`define BCS_MEM_RANGE_LSB 8
`define BCS_MEM_RATIO_LSB 10
`define BCS_MEM_SYNC_BIT 184
`define BCS_MEM_RATE_BIT 232
`define BCS_MEM_RSV_BIT 234
`define BCS_CORE_SEL_LSB 16
`define BCS_SD_RATIO_LSB 48
`define BCS_SD_DIV1_LSB 57
`define BCS_SD_DIV2_BIT 62
`define BCS_SD_DIV3_BIT 63
`define BCS_FM_SEL_LSB 64
`define BCS_PME_SEL_BIT 66

// core select codes, cores 0 to 3
`define BCS_LO_P1D1 4'h0
`define BCS_LO_P1D2 4'h1
`define BCS_LO_P2D1 4'h4
`define BCS_LO_P2D2 4'h5
`define BCS_LO_P3D2 4'h8
// core select codes, cores 4 to 7
`define BCS_HI_P1D1 4'h0
`define BCS_HI_P3D1 4'h8
`define BCS_HI_P3D2 4'h9
`define BCS_HI_P4D1 4'hC
`define BCS_HI_P4D2 4'hD

// memory ratio codes; asynchronous code value equals the ratio
`define BCS_AR_5 5'h05
`define BCS_AR_6 5'h06
`define BCS_AR_8 5'h08
`define BCS_AR_9 5'h09
`define BCS_AR_10 5'h0A
`define BCS_AR_12 5'h0C
`define BCS_AR_13 5'h0D
`define BCS_AR_16 5'h10
`define BCS_SYNC_RATIO 5'h01
`define BCS_SYNC_MULT 5'h01

// serdes ratio codes and multipliers
`define BCS_SD_R10 3'h0
`define BCS_SD_R20 3'h1
`define BCS_SD_R25 3'h2
`define BCS_SD_R40 3'h3
`define BCS_SD_R50 3'h4
`define BCS_SD_M10 6'h0A
`define BCS_SD_M20 6'h14
`define BCS_SD_M25 6'h19
`define BCS_SD_M40 6'h28
`define BCS_SD_M50 6'h32
`define BCS_SD_RSV 7'h40

// register byte addresses
`define BCS_REG_ERR 4'h0
`define BCS_REG_MASK 4'h4
`define BCS_REG_SUM 4'h8

`endif

// ### bcs_pkg.sv
// Purpose: shared types of the boot clock source select block
// Assumes: nothing
// Notes: state codes are Gray along the load path
package bcs_pkg;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_DECODE = 2'h1,
        ST_HELD = 2'h3
    } bcs_state_t;

    typedef enum logic [1:0] {
        PLL_CLUSTER1 = 2'h0,
        PLL_CLUSTER2 = 2'h1,
        PLL_CLUSTER3 = 2'h2,
        PLL_CLUSTER4 = 2'h3
    } bcs_pll_t;

endpackage : bcs_pkg

// ### bcs_dec_if.sv
// Purpose: carrier between the top and one core select decoder
// Assumes: bcs_pkg compiled first
// Notes: purely combinational signals
`timescale 1ns/1ns
`default_nettype none
interface bcs_dec_if;
    logic [3:0] code;
    logic hi_group;
    bcs_pkg::bcs_pll_t src;
    logic div2;
    logic rsv;
    modport dec (input code, input hi_group, output src, output div2, output rsv);
    modport user (output code, output hi_group, input src, input div2, input rsv);
endinterface : bcs_dec_if
`default_nettype wire

// ### bcs_core_dec.sv
// Purpose: decode one core complex select code to source and divider
// Assumes: bcs_params.svh and bcs_pkg available
// Notes: reserved codes report rsv and fall back to cluster pll 1 /1
`timescale 1ns/1ns
`default_nettype none
`include "bcs_params.svh"
module bcs_core_dec (
    bcs_dec_if.dec p
);

    // two selection sets: lower and upper core group
    always_comb begin
        p.src = bcs_pkg::PLL_CLUSTER1;
        p.div2 = 1'b0;
        p.rsv = 1'b0;
        if (!p.hi_group) begin
            case (p.code)
                `BCS_LO_P1D1: p.src = bcs_pkg::PLL_CLUSTER1;
                `BCS_LO_P1D2: p.div2 = 1'b1;
                `BCS_LO_P2D1: p.src = bcs_pkg::PLL_CLUSTER2;
                `BCS_LO_P2D2: begin
                    p.src = bcs_pkg::PLL_CLUSTER2;
                    p.div2 = 1'b1;
                end
                `BCS_LO_P3D2: begin
                    p.src = bcs_pkg::PLL_CLUSTER3;
                    p.div2 = 1'b1;
                end
                default: p.rsv = 1'b1;
            endcase
        end else begin
            case (p.code)
                `BCS_HI_P1D1: p.src = bcs_pkg::PLL_CLUSTER1;
                `BCS_HI_P3D1: p.src = bcs_pkg::PLL_CLUSTER3;
                `BCS_HI_P3D2: begin
                    p.src = bcs_pkg::PLL_CLUSTER3;
                    p.div2 = 1'b1;
                end
                `BCS_HI_P4D1: p.src = bcs_pkg::PLL_CLUSTER4;
                `BCS_HI_P4D2: begin
                    p.src = bcs_pkg::PLL_CLUSTER4;
                    p.div2 = 1'b1;
                end
                default: p.rsv = 1'b1;
            endcase
        end
    end

endmodule : bcs_core_dec
`default_nettype wire

// ### bcs_clock_select.sv
// Purpose: decode the reset configuration word into clock source selections
// Assumes: configuration word valid and steady from reset release on
// Notes: the word is captured once per reset; selection outputs then hold until reset
//
// Implementation choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ns
`default_nettype none
`include "bcs_params.svh"

module bcs_clock_select #(
    parameter int CORES = `BCS_CORES,
    parameter int RCW_W = `BCS_RCW_W
) (
    input wire logic CORE_CLK,
    input wire logic SYS_RST,
    input wire logic CLK_EN,
    input wire logic [RCW_W-1:0] RCW_WORD,
    input wire logic [3:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WE,
    input wire logic REG_RE,
    output logic [31:0] REG_RDATA,
    output wire logic [2*CORES-1:0] CORE_SRC,
    output wire logic [CORES-1:0] CORE_DIV2,
    output logic MEM_REF_PLAT,
    output logic MEM_SYNC,
    output logic [4:0] MEM_MULT,
    output logic [1:0] MEM_RANGE,
    output logic [17:0] SD_MULT,
    output logic [6:0] SD_LANE_DIV2,
    output logic [1:0] FM_SRC_PLL3,
    output logic PME_SRC_PLL3,
    output logic CFG_VALID,
    output logic CFG_ERR
);

    // error bits: cores, mem ratio, mode mismatch, mem reserved bit, serdes banks
    localparam int EW = CORES + 6;

    bcs_pkg::bcs_state_t state_q;
    logic [RCW_W-1:0] rcw_q;
    logic [EW-1:0] err_q;
    logic [EW-1:0] err_d;
    logic [EW-1:0] mask_q;
    logic [EW-1:0] wr_mask;
    logic [4:0] mem_mult_d;
    logic [4:0] mem_code;
    logic mem_sync;
    logic err_hit;
    logic decode_now;
    wire [CORES-1:0] core_rsv;
    wire [17:0] sd_mult_d;
    wire [2:0] sd_rsv_d;

    // load sequence: capture in idle, decode once, then hold until reset
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            state_q <= bcs_pkg::ST_IDLE;
        end else if (CLK_EN) begin
            case (state_q)
                bcs_pkg::ST_IDLE: state_q <= bcs_pkg::ST_DECODE;
                bcs_pkg::ST_DECODE: state_q <= bcs_pkg::ST_HELD;
                bcs_pkg::ST_HELD: state_q <= bcs_pkg::ST_HELD;
                default: state_q <= bcs_pkg::ST_IDLE;
            endcase
        end
    end

    assign decode_now = CLK_EN && (state_q == bcs_pkg::ST_DECODE);

    // single sample of the word; later changes of the pins are ignored
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            rcw_q <= '0;
        end else if (CLK_EN && state_q == bcs_pkg::ST_IDLE) begin
            rcw_q <= RCW_WORD;
        end
    end

    // one decoder per core complex, independent of its neighbours
    for (genvar i = 0; i < CORES; i++) begin : g_core
        bcs_dec_if u_if ();
        logic [1:0] src_q;
        logic div_q;
        assign u_if.code = rcw_q[`BCS_CORE_SEL_LSB + 4*i +: 4];
        assign u_if.hi_group = (i >= CORES / 2) ? 1'b1 : 1'b0;
        assign core_rsv[i] = u_if.rsv;
        bcs_core_dec u_dec (
            .p(u_if.dec)
        );
        always_ff @(posedge CORE_CLK) begin
            if (SYS_RST) begin
                src_q <= 2'h0;
                div_q <= 1'b0;
            end else if (decode_now) begin
                src_q <= u_if.src;
                div_q <= u_if.div2;
            end
        end
        assign CORE_SRC[2*i +: 2] = src_q;
        assign CORE_DIV2[i] = div_q;
    end

    // memory ratio decode; async codes carry the ratio as their own value
    assign mem_code = rcw_q[`BCS_MEM_RATIO_LSB +: 5];
    assign mem_sync = rcw_q[`BCS_MEM_SYNC_BIT];
    always_comb begin
        mem_mult_d = 5'h00;
        if (mem_sync) begin
            if (mem_code == `BCS_SYNC_RATIO) begin
                mem_mult_d = `BCS_SYNC_MULT;
            end
        end else begin
            case (mem_code)
                `BCS_AR_5, `BCS_AR_6, `BCS_AR_8, `BCS_AR_9,
                `BCS_AR_10, `BCS_AR_12, `BCS_AR_13, `BCS_AR_16: mem_mult_d = mem_code;
                default: mem_mult_d = 5'h00;
            endcase
        end
    end

    // serdes multiplier decode; top bit of result marks a reserved code
    function automatic logic [6:0] sd_dec(input logic [2:0] code, input logic bank1);
        logic [6:0] r;
        r = `BCS_SD_RSV;
        case (code)
            `BCS_SD_R10: r = {1'b0, `BCS_SD_M10};
            `BCS_SD_R20: r = {1'b0, `BCS_SD_M20};
            `BCS_SD_R25: r = {1'b0, `BCS_SD_M25};
            `BCS_SD_R40: r = bank1 ? {1'b0, `BCS_SD_M40} : `BCS_SD_RSV;
            `BCS_SD_R50: r = bank1 ? {1'b0, `BCS_SD_M50} : `BCS_SD_RSV;
            default: r = `BCS_SD_RSV;
        endcase
        return r;
    endfunction : sd_dec

    for (genvar b = 0; b < 3; b++) begin : g_bank
        wire [6:0] res;
        assign res = sd_dec(rcw_q[`BCS_SD_RATIO_LSB + 3*b +: 3], (b == 0) ? 1'b1 : 1'b0);
        assign sd_mult_d[6*b +: 6] = res[5:0];
        assign sd_rsv_d[b] = res[6];
    end

    // error collection; the two mode bits must agree and the spare bit stay low
    assign err_d = {sd_rsv_d,
                    rcw_q[`BCS_MEM_RSV_BIT],
                    rcw_q[`BCS_MEM_SYNC_BIT] ^ rcw_q[`BCS_MEM_RATE_BIT],
                    (mem_mult_d == 5'h00),
                    core_rsv};

    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            err_q <= '0;
        end else if (decode_now) begin
            err_q <= err_d;
        end
    end

    // memory outputs: one set feeds both controllers, so they cannot differ
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            MEM_SYNC <= 1'b0;
            MEM_REF_PLAT <= 1'b0;
            MEM_MULT <= 5'h00;
            MEM_RANGE <= 2'h0;
        end else if (decode_now) begin
            MEM_SYNC <= mem_sync;
            MEM_REF_PLAT <= mem_sync;
            MEM_MULT <= mem_mult_d;
            MEM_RANGE <= rcw_q[`BCS_MEM_RANGE_LSB +: 2];
        end
    end

    // serdes multipliers and lane dividers
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            SD_MULT <= 18'h00000;
            SD_LANE_DIV2 <= 7'h00;
        end else if (decode_now) begin
            SD_MULT <= sd_mult_d;
            SD_LANE_DIV2[4:0] <= rcw_q[`BCS_SD_DIV1_LSB +: 5];
            SD_LANE_DIV2[5] <= rcw_q[`BCS_SD_DIV2_BIT];
            SD_LANE_DIV2[6] <= rcw_q[`BCS_SD_DIV3_BIT];
        end
    end

    // frame manager and pattern engine source muxes
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            FM_SRC_PLL3 <= 2'h0;
            PME_SRC_PLL3 <= 1'b0;
        end else if (decode_now) begin
            FM_SRC_PLL3 <= rcw_q[`BCS_FM_SEL_LSB +: 2];
            PME_SRC_PLL3 <= rcw_q[`BCS_PME_SEL_BIT];
        end
    end

    // valid rises after the decode cycle and stays until reset
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            CFG_VALID <= 1'b0;
        end else if (decode_now) begin
            CFG_VALID <= 1'b1;
        end
    end

    // error mask, software writable; all errors enabled after reset
    assign wr_mask = REG_WDATA[EW-1:0];
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            mask_q <= '1;
        end else if (CLK_EN && REG_WE && REG_ADDR == `BCS_REG_MASK) begin
            mask_q <= wr_mask;
        end
    end

    // registered error output; masking lets software accept a known odd word
    assign err_hit = |(err_q & mask_q);
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            CFG_ERR <= 1'b0;
        end else if (CLK_EN) begin
            CFG_ERR <= err_hit;
        end
    end

    // read port: data in the cycle after an enabled strobe, zero after other enabled cycles, held while CLK_EN is low
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            REG_RDATA <= 32'h00000000;
        end else if (CLK_EN) begin
            if (REG_RE) begin
                case (REG_ADDR)
                    `BCS_REG_ERR: REG_RDATA <= 32'(err_q);
                    `BCS_REG_MASK: REG_RDATA <= 32'(mask_q);
                    `BCS_REG_SUM: REG_RDATA <= 32'({CFG_VALID, state_q, MEM_SYNC, MEM_MULT});
                    default: REG_RDATA <= 32'h00000000;
                endcase
            end else begin
                REG_RDATA <= 32'h00000000;
            end
        end
    end

    // checks
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (SYS_RST);

    sequence s_capture;
        state_q == bcs_pkg::ST_IDLE && CLK_EN;
    endsequence

    sequence s_decode;
        state_q == bcs_pkg::ST_DECODE && CLK_EN;
    endsequence

    property p_load_flow;
        s_capture ##1 s_decode |=> CFG_VALID && state_q == bcs_pkg::ST_HELD;
    endproperty

    a_load_flow: assert property (p_load_flow)
        else $error("valid not raised after decode");

    a_held_stable: assert property (
        CFG_VALID && $past(CFG_VALID) |-> $stable(CORE_SRC) && $stable(MEM_MULT)
            && $stable(SD_MULT))
        else $error("selection changed after load");

    a_mem_ref: assert property (
        CFG_VALID |-> MEM_REF_PLAT == rcw_q[`BCS_MEM_SYNC_BIT])
        else $error("memory reference not tied to mode");

    a_sync_ratio: assert property (
        CFG_VALID && MEM_SYNC && mem_code != `BCS_SYNC_RATIO
            |-> MEM_MULT == 5'h00 && err_q[CORES])
        else $error("reserved sync ratio not flagged");

    a_core_lo_decode: assert property (
        CFG_VALID && rcw_q[`BCS_CORE_SEL_LSB +: 4] == `BCS_LO_P2D2
            |-> CORE_SRC[1:0] == 2'h1 && CORE_DIV2[0] && !err_q[0])
        else $error("core 0 decode wrong");

    a_core_hi_decode: assert property (
        CFG_VALID && rcw_q[`BCS_CORE_SEL_LSB + 4*(CORES-1) +: 4] == `BCS_HI_P4D2
            |-> CORE_SRC[2*CORES-1 -: 2] == 2'h3 && CORE_DIV2[CORES-1])
        else $error("last core decode wrong");

    a_sd_bank_limit: assert property (
        CFG_VALID && rcw_q[`BCS_SD_RATIO_LSB + 3 +: 3] == `BCS_SD_R40
            |-> SD_MULT[11:6] == 6'h00 && err_q[CORES+4])
        else $error("bank 2 accepted a bank 1 only ratio");

    a_lane_div: assert property (
        CFG_VALID |-> SD_LANE_DIV2[4:0] == rcw_q[`BCS_SD_DIV1_LSB +: 5])
        else $error("bank 1 lane dividers wrong");

    a_err_out: assert property (
        CLK_EN |=> CFG_ERR == $past(err_hit))
        else $error("error output does not follow masked errors");

    a_read_err: assert property (
        CLK_EN && REG_RE && REG_ADDR == `BCS_REG_ERR && state_q == bcs_pkg::ST_HELD
            |=> REG_RDATA == 32'(err_q))
        else $error("error register read wrong");

    a_mask_write: assert property (
        CLK_EN && REG_WE && REG_ADDR == `BCS_REG_MASK |=> mask_q == $past(wr_mask))
        else $error("mask write lost");

endmodule : bcs_clock_select
`default_nettype wire

// ### bcs_rcw_src.sv
// Purpose: model of the reset configuration word source
// Assumes: fields placed at the positions chosen for the decoder
// Notes: after capture the word is inverted so a decoder that re-reads it is caught
`timescale 1ns/1ns
`default_nettype none
module bcs_rcw_src (
    input wire logic [31:0] core_codes,
    input wire logic [4:0] mem_ratio,
    input wire logic sync_mode,
    input wire logic [1:0] range_sel,
    input wire logic rate_bad,
    input wire logic rsv_bad,
    input wire logic [8:0] sd_ratio,
    input wire logic [6:0] sd_div,
    input wire logic [2:0] fm_pme,
    input wire logic released,
    output logic [255:0] word
);
    logic [255:0] w;

    // assemble the word; rate_bad and rsv_bad break the source rules on purpose
    always_comb begin
        w = '0;
        w[9:8] = range_sel;
        w[14:10] = mem_ratio;
        w[47:16] = core_codes;
        w[56:48] = sd_ratio;
        w[63:57] = sd_div;
        w[66:64] = fm_pme;
        w[184] = sync_mode;
        w[232] = sync_mode ^ rate_bad;
        w[234] = rsv_bad;
    end

    // a released source no longer shows its last value
    assign word = released ? ~w : w;
endmodule : bcs_rcw_src
`default_nettype wire

// ### bcs_clock_select_test.sv
// Purpose: self-checking bench for the clock source select decoder
// Assumes: bcs_pkg, bcs_dec_if, decoder files compiled first
// Notes: each pass resets, loads one word, compares outputs and registers
`timescale 1ns/1ns
`default_nettype none
module bcs_clock_select_test;
    logic core_clk = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, released = 1'b0;
    logic [31:0] codes = '0;
    logic [4:0] ratio = '0;
    logic sync = 1'b0, rate_bad = 1'b0, rsv_bad = 1'b0;
    logic [1:0] rng = '0;
    logic [8:0] sdr = '0;
    logic [6:0] sdd = '0;
    logic [2:0] fmp = '0;
    logic [3:0] reg_addr = '0;
    logic [31:0] reg_wdata = '0;
    logic reg_we = 1'b0, reg_re = 1'b0;
    logic [255:0] rcw;
    logic [31:0] reg_rdata;
    logic [15:0] core_src, e_src;
    logic [7:0] core_div2, e_div;
    logic mem_ref_plat, mem_sync, pme_src, cfg_valid, cfg_err;
    logic [4:0] mem_mult, e_mult;
    logic [1:0] mem_range, fm_src;
    logic [17:0] sd_mult, e_sd;
    logic [6:0] sd_lane_div2;
    logic [13:0] e_err;
    int n_fail = 0, n_tests = 0, seed_v;

    // 125 MHz
    always #4 core_clk = ~core_clk;

    bcs_rcw_src u_bcs_rcw_src (.core_codes(codes), .mem_ratio(ratio), .sync_mode(sync),
        .range_sel(rng), .rate_bad(rate_bad), .rsv_bad(rsv_bad), .sd_ratio(sdr),
        .sd_div(sdd), .fm_pme(fmp), .released(released), .word(rcw));

    bcs_clock_select u_bcs_clock_select (.CORE_CLK(core_clk), .SYS_RST(sys_rst),
        .CLK_EN(clk_en), .RCW_WORD(rcw), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_WE(reg_we), .REG_RE(reg_re), .REG_RDATA(reg_rdata), .CORE_SRC(core_src),
        .CORE_DIV2(core_div2), .MEM_REF_PLAT(mem_ref_plat), .MEM_SYNC(mem_sync),
        .MEM_MULT(mem_mult), .MEM_RANGE(mem_range), .SD_MULT(sd_mult),
        .SD_LANE_DIV2(sd_lane_div2), .FM_SRC_PLL3(fm_src), .PME_SRC_PLL3(pme_src),
        .CFG_VALID(cfg_valid), .CFG_ERR(cfg_err));

    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : stop_test

    task automatic reg_wr(logic [3:0] a, logic [31:0] d);
        @(posedge core_clk);
        reg_we <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_we <= 1'b0;
    endtask : reg_wr

    // read data stands only in the cycle after the strobe, then returns to zero
    task automatic reg_rd(string what, logic [3:0] a, logic [31:0] exp);
        @(posedge core_clk);
        reg_re <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_re <= 1'b0;
        #1 chk(what, exp, reg_rdata);
        @(posedge core_clk);
        #1 chk("rdata_idle", 32'h0, reg_rdata);
    endtask : reg_rd

    // reference decode; m packs source*2+div, -1 marks a reserved code
    task automatic model();
        int c, m;
        e_err = '0;
        for (int n = 0; n < 8; n++) begin
            c = codes[4*n+:4];
            m = (n < 4) ? ((c == 0) ? 0 : (c == 1) ? 1 : (c == 4) ? 2 : (c == 5) ? 3 :
                (c == 8) ? 5 : -1) : ((c == 0) ? 0 : (c == 8) ? 4 : (c == 9) ? 5 :
                (c == 12) ? 6 : (c == 13) ? 7 : -1);
            e_err[n] = (m < 0);
            m = (m < 0) ? 0 : m;
            e_src[2*n+:2] = 2'(m / 2);
            e_div[n] = m[0];
        end
        if (sync) begin
            e_mult = (ratio == 5'h01) ? 5'h01 : 5'h00;
        end else begin
            e_mult = (ratio inside {5'h05, 5'h06, 5'h08, 5'h09, 5'h0A, 5'h0C, 5'h0D,
                5'h10}) ? ratio : 5'h00;
        end
        e_err[8] = (e_mult == 5'h00);
        e_err[9] = rate_bad;
        e_err[10] = rsv_bad;
        for (int b = 0; b < 3; b++) begin
            c = sdr[3*b+:3];
            m = (c == 0) ? 10 : (c == 1) ? 20 : (c == 2) ? 25 : (c == 3 && b == 0) ? 40 :
                (c == 4 && b == 0) ? 50 : 0;
            e_sd[6*b+:6] = 6'(m);
            e_err[11+b] = (m == 0);
        end
    endtask : model

    // one reset and load; core codes sweep every code, then random; memory ratio every code, then 5'h01 and random in turn; serdes and mux fields always random
    task automatic run_cfg(int i);
        logic [31:0] cw;
        logic [13:0] mk;
        int ref_mhz;
        for (int n = 0; n < 8; n++) begin
            cw[4*n+:4] = 4'(i + n);
        end
        ref_mhz = 500 + ($urandom % 200);
        @(posedge core_clk);
        sys_rst <= 1'b1;
        released <= 1'b0;
        codes <= (i < 16) ? cw : $urandom;
        sync <= (i >= 32);
        ratio <= (i < 32) ? 5'(i) : ((i % 2) ? 5'h01 : 5'($urandom));
        rng <= (i >= 32 && ref_mhz > 600) ? 2'h1 : 2'h0;
        rate_bad <= (i % 7 == 3);
        rsv_bad <= (i % 9 == 4);
        sdr <= 9'($urandom);
        sdd <= 7'($urandom);
        fmp <= 3'($urandom);
        repeat (10) @(posedge core_clk);
        sys_rst <= 1'b0;
        clk_en <= 1'b0;
        repeat (3) @(posedge core_clk);
        #1 chk("valid_frozen", 32'h0, 32'(cfg_valid));
        @(posedge core_clk);
        clk_en <= 1'b1;
        @(posedge core_clk);
        #1 chk("valid_capture", 32'h0, 32'(cfg_valid));
        @(posedge core_clk);
        #1 chk("valid_load", 32'h1, 32'(cfg_valid));
        released <= 1'b1;
        model();
        repeat (3) @(posedge core_clk);
        #1 chk("core_src", 32'(e_src), 32'(core_src));
        chk("core_div2", 32'(e_div), 32'(core_div2));
        chk("mem_ref", 32'(sync), 32'(mem_ref_plat));
        chk("mem_sync", 32'(sync), 32'(mem_sync));
        chk("mem_mult", 32'(e_mult), 32'(mem_mult));
        chk("mem_range", 32'(rng), 32'(mem_range));
        chk("sd_mult", 32'(e_sd), 32'(sd_mult));
        chk("sd_div", 32'(sdd), 32'(sd_lane_div2));
        chk("fm_src", 32'(fmp[1:0]), 32'(fm_src));
        chk("pme_src", 32'(fmp[2]), 32'(pme_src));
        chk("cfg_err", 32'(|e_err), 32'(cfg_err));
        reg_rd("mask_rst", 4'h4, 32'h3FFF);
        reg_rd("err", 4'h0, 32'(e_err));
        reg_rd("sum", 4'h8, 32'({1'b1, 2'h3, sync, e_mult}));
        mk = 14'($urandom);
        reg_wr(4'h0, 32'hFFFFFFFF);
        reg_wr(4'hC, 32'hFFFFFFFF);
        reg_wr(4'h4, {18'h3FFFF, mk});
        reg_rd("unmapped", 4'hC, 32'h0);
        reg_rd("err_ro", 4'h0, 32'(e_err));
        reg_rd("mask", 4'h4, 32'(mk));
        chk("cfg_err_mask", 32'(|(e_err & mk)), 32'(cfg_err));
    endtask : run_cfg

    // hang guard: a stuck run is reported as a mismatch
    initial begin
        #400000;
        n_fail++;
        stop_test();
    end

    initial begin
        seed_v = $urandom(32'h7022c656);
        for (int i = 0; i < 48; i++) begin
            run_cfg(i);
        end
        stop_test();
    end
endmodule : bcs_clock_select_test
`default_nettype wire
